//--- rtl/route_pkg.sv
package route_pkg;

  // ***************************************
  // sizes
  // ***************************************
  localparam int NUM_FIFO = 8;
  localparam int FIFO_IDX_W = 3;
  localparam int CH_W = 5;
  localparam int NUM_CH = 32;
  localparam int NUM_SLOT = 32;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 4;

  // ***************************************
  // directions and channel classes
  // ***************************************
  localparam logic DIR_TX = 1'b0;
  localparam logic DIR_RX = 1'b1;
  // e-channel positions: 3, 7, 11 ... 31, so the two low bits are both set
  localparam logic [1:0] E_CH_LOW_BITS = 2'h3;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [DATA_W-1:0] FILL_MASK_RST = 8'hFF;
  localparam logic [DATA_W-1:0] FIFO_BITS_RST = 8'hFF;
  localparam logic [CH_W-1:0] CH_RST = 5'h00;
  localparam logic [7:0] DROP_CNT_MAX = 8'hFF;

  // ***************************************
  // output word layout
  // ***************************************
  localparam int OUT_DATA_LSB = 0;
  localparam int OUT_MASK_LSB = 8;
  localparam int OUT_IDX_LSB = 16;
  localparam int OUT_KIND_LSB = 21;
  localparam int OUT_W = 23;

  // ***************************************
  // enumerations
  // ***************************************
  typedef enum logic [1:0] {
    SRC_HOST = 2'b00,
    SRC_PCM = 2'b01,
    SRC_LINE = 2'b10
  } src_e;

  typedef enum logic [1:0] {
    DST_NONE = 2'b00,
    DST_HOST = 2'b01,
    DST_PCM = 2'b10,
    DST_LINE = 2'b11
  } dst_e;

  typedef enum logic [1:0] {
    CFG_FIFO = 2'b00,
    CFG_SLOT = 2'b01,
    CFG_FILL = 2'b10,
    CFG_MODE = 2'b11
  } cfg_e;

endpackage

//--- rtl/stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/route_buf.sv
`timescale 1ns/1ns
`default_nettype none
module route_buf #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  stream_if.snk push,
  stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  wire do_push = push.valid && !full_reg;
  wire do_pop = pop.ready && !empty_reg;

  // flags come from flops so ready and valid are glitch free at the ports
  assign push.ready = !full_reg;
  assign pop.valid = !empty_reg;
  assign pop.data = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);

  // storage, no reset needed on data
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= push.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
      rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
      count_reg <= count_next;
      full_reg <= (count_next == DEPTH_C);
      empty_reg <= (count_next == '0);
    end
  end
endmodule
`default_nettype wire

//--- rtl/channel_select_routing.sv
// Notes on behaviour
// RULE1 - a pcm to line coupling ties up one tx and one rx fifo but no byte is stored in them.
// RULE2 - no pcm to line byte passes unless both fifos of the coupling are enabled.
// RULE3 - fifos of one direction on the same channel number are merged onto that one channel.
// RULE4 - the e-channel positions 3, 7 .. 31 may be used as ordinary routing channels.
// RULE5 - per-fifo bit masks shape the byte but never change which path is linked.
// RULE6 - in arbitrary mode a used channel needs an enabled fifo of its direction, pcm to pcm aside.
// RULE7 - in arbitrary mode a used pcm slot must be linked to a channel by its slot setting.
// RULE8 - a full duplex pcm to pcm path uses one channel both ways and needs no fifo.
// RULE9 - arbitrary mode is on when the assignment bit is one and the sequence bit is zero.
// RULE10 - each fifo is joined to the channel written in its channel number field; in simple mode the code ties fifo n to channel n instead.
// RULE11 - transparent fifos keep a full byte per frame, hdlc fifos scale with their bits.
// RULE12 - bits of a shared byte that no fifo drives come from the fill mask byte.
// RULE13 - software sets each fifo's channel direction equal to the fifo's own direction.
`timescale 1ns/1ns
`default_nettype none
module channel_select_routing (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_we_i,
  input wire route_pkg::cfg_e cfg_target_i,
  input wire logic cfg_dir_i,
  input wire logic [route_pkg::CH_W-1:0] cfg_index_i,
  input wire logic [route_pkg::CH_W-1:0] cfg_channel_i,
  input wire logic cfg_chdir_i,
  input wire logic cfg_enable_i,
  input wire logic [route_pkg::DATA_W-1:0] cfg_bits_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire route_pkg::src_e in_source_i,
  input wire logic [route_pkg::CH_W-1:0] in_index_i,
  input wire logic [route_pkg::DATA_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [route_pkg::OUT_W-1:0] out_word_o,
  output logic mode_active_o,
  output logic e_route_seen_o,
  output logic [7:0] drop_count_o
);
  import route_pkg::*;

  // ***************************************
  // configuration store
  // ***************************************
  logic [CH_W-1:0] fch_reg [2][NUM_FIFO];
  logic fdir_reg [2][NUM_FIFO];
  logic fen_reg [2][NUM_FIFO];
  logic [DATA_W-1:0] fbits_reg [2][NUM_FIFO];
  logic [CH_W-1:0] sch_reg [2][NUM_SLOT];
  logic slink_reg [2][NUM_SLOT];
  logic [DATA_W-1:0] fill_reg;
  logic assign_bit_reg;
  logic seq_bit_reg;
  logic [DATA_W-1:0] acc_reg [NUM_CH];

  wire mode_active = assign_bit_reg && !seq_bit_reg; // RULE9

  // channel a fifo feeds; simple mode ties fifo n to channel n
  function automatic logic [CH_W-1:0] eff_ch(input logic d, input logic [FIFO_IDX_W-1:0] f);
    eff_ch = mode_active ? fch_reg[d][f] : {2'b00, f}; // RULE10
  endfunction

  // a fifo takes part only when enabled and, in arbitrary mode, with matching channel direction
  function automatic logic fifo_live(input logic d, input logic [FIFO_IDX_W-1:0] f);
    fifo_live = fen_reg[d][f] && (!mode_active || fdir_reg[d][f] == d); // RULE13
  endfunction

  // config writes, one target per cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int d = 0; d < 2; d++)
      begin
        for (int f = 0; f < NUM_FIFO; f++)
        begin
          fch_reg[d][f] <= CH_RST;
          fdir_reg[d][f] <= DIR_TX;
          fen_reg[d][f] <= 1'b0;
          fbits_reg[d][f] <= FIFO_BITS_RST;
        end
        for (int s = 0; s < NUM_SLOT; s++)
        begin
          sch_reg[d][s] <= CH_RST;
          slink_reg[d][s] <= 1'b0;
        end
      end
      fill_reg <= FILL_MASK_RST;
      assign_bit_reg <= 1'b0;
      seq_bit_reg <= 1'b0;
    end
    else if (cfg_we_i)
    begin
      case (cfg_target_i)
        CFG_FIFO:
        begin
          fch_reg[cfg_dir_i][cfg_index_i[FIFO_IDX_W-1:0]] <= cfg_channel_i;
          fdir_reg[cfg_dir_i][cfg_index_i[FIFO_IDX_W-1:0]] <= cfg_chdir_i;
          fen_reg[cfg_dir_i][cfg_index_i[FIFO_IDX_W-1:0]] <= cfg_enable_i;
          fbits_reg[cfg_dir_i][cfg_index_i[FIFO_IDX_W-1:0]] <= cfg_bits_i;
        end
        CFG_SLOT:
        begin
          sch_reg[cfg_dir_i][cfg_index_i] <= cfg_channel_i;
          slink_reg[cfg_dir_i][cfg_index_i] <= cfg_enable_i;
        end
        CFG_FILL: fill_reg <= cfg_bits_i;
        CFG_MODE:
        begin
          assign_bit_reg <= cfg_bits_i[0];
          seq_bit_reg <= cfg_bits_i[1];
        end
        default: fill_reg <= fill_reg;
      endcase
    end
  end

  // ***************************************
  // route lookup
  // ***************************************
  logic [CH_W-1:0] key_ch;
  logic [NUM_FIFO-1:0] tx_hit;
  logic [NUM_FIFO-1:0] rx_hit;
  logic [DATA_W-1:0] owned;
  logic [DATA_W-1:0] rx_owned;
  logic pcm_hit;
  logic [CH_W-1:0] pcm_slot;
  dst_e route_dst;
  logic [CH_W-1:0] route_idx;
  logic [DATA_W-1:0] route_data;
  logic [DATA_W-1:0] merged;
  logic [FIFO_IDX_W-1:0] in_fifo;
  logic slot_linked;
  logic in_fire;
  logic push_ready;

  assign in_fifo = in_index_i[FIFO_IDX_W-1:0];
  assign slot_linked = slink_reg[DIR_RX][in_index_i] || !mode_active; // RULE7
  assign in_fire = in_valid_i && push_ready;

  // e-channel numbers are not fenced off, any of 0..31 routes alike
  always_comb
  begin
    case (in_source_i)
      SRC_HOST: key_ch = eff_ch(DIR_TX, in_fifo);
      SRC_PCM: key_ch = mode_active ? sch_reg[DIR_RX][in_index_i] : in_index_i; // RULE7
      default: key_ch = in_index_i; // RULE4
    endcase
  end

  // who sits on the channel; bit masks only shape data, never the match
  always_comb
  begin
    tx_hit = '0;
    rx_hit = '0;
    owned = '0;
    rx_owned = '0;
    pcm_hit = 1'b0;
    pcm_slot = '0;
    for (int f = 0; f < NUM_FIFO; f++)
    begin
      tx_hit[f] = fifo_live(DIR_TX, FIFO_IDX_W'(f)) && eff_ch(DIR_TX, FIFO_IDX_W'(f)) == key_ch;
      rx_hit[f] = fifo_live(DIR_RX, FIFO_IDX_W'(f)) && eff_ch(DIR_RX, FIFO_IDX_W'(f)) == key_ch;
      if (tx_hit[f])
      begin
        owned = owned | fbits_reg[DIR_TX][f]; // RULE3
      end
      if (rx_hit[f])
      begin
        rx_owned = rx_owned | fbits_reg[DIR_RX][f]; // RULE5
      end
    end
    for (int s = NUM_SLOT - 1; s >= 0; s--)
    begin
      if (slink_reg[DIR_TX][s] && sch_reg[DIR_TX][s] == key_ch)
      begin
        pcm_hit = 1'b1;
        pcm_slot = CH_W'(s);
      end
    end
  end

  // merge this fifo's bits into the channel byte, the other bits keep the accumulator value
  assign merged = (acc_reg[key_ch] & ~fbits_reg[DIR_TX][in_fifo])
                | (in_data_i & fbits_reg[DIR_TX][in_fifo]); // RULE11
  // decide destination; a coupled byte goes straight through, never stored
  always_comb
  begin
    route_dst = DST_NONE;
    route_idx = key_ch;
    route_data = in_data_i;
    case (in_source_i)
      SRC_HOST:
      begin
        if (fifo_live(DIR_TX, in_fifo)) // RULE6
        begin
          route_dst = DST_LINE;
          route_data = (merged & owned) | (fill_reg & ~owned); // RULE12
        end
      end
      SRC_PCM:
      begin
        if (slot_linked && pcm_hit && mode_active)
        begin
          route_dst = DST_PCM; // RULE8
          route_idx = pcm_slot;
        end
        else if (slot_linked && (|tx_hit) && (|rx_hit))
        begin
          route_dst = DST_LINE; // RULE2
        end
      end
      SRC_LINE:
      begin
        if ((|rx_hit) && pcm_hit && (|tx_hit))
        begin
          route_dst = DST_PCM; // RULE1
          route_idx = pcm_slot;
        end
        else if (|rx_hit)
        begin
          route_dst = DST_HOST; // RULE3
        end
      end
      default: route_dst = DST_NONE;
    endcase
  end

  // channel byte accumulators, only host transmit bytes touch them
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        acc_reg[c] <= FILL_MASK_RST;
      end
    end
    else if (in_fire && in_source_i == SRC_HOST && route_dst == DST_LINE)
    begin
      acc_reg[key_ch] <= merged; // RULE3
    end
  end

  // ***************************************
  // buffer and output stage
  // ***************************************
  stream_if #(.W(OUT_W)) push_if ();
  stream_if #(.W(OUT_W)) pop_if ();
  logic out_valid_reg;
  logic [OUT_W-1:0] out_word_reg;
  logic [7:0] drop_count_reg;
  logic e_seen_reg;
  logic mode_reg;
  wire take_out = pop_if.valid && (!out_valid_reg || out_ready_i);

  assign push_ready = push_if.ready;
  assign push_if.valid = in_fire && route_dst != DST_NONE;
  assign push_if.data = {route_dst, route_idx,
                         (route_dst == DST_HOST) ? rx_owned : 8'h00, route_data};
  assign pop_if.ready = !out_valid_reg || out_ready_i;

  route_buf #(.W(OUT_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // a full buffer refuses the byte through push_ready, but in_ready_o stays high so the source is not held off
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_reg <= 1'b0;
      out_word_reg <= '0;
      drop_count_reg <= '0;
      e_seen_reg <= 1'b0;
      mode_reg <= 1'b0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      if (take_out)
      begin
        out_word_reg <= pop_if.data;
      end
      out_valid_reg <= take_out || (out_valid_reg && !out_ready_i);
      if (in_fire && route_dst == DST_NONE && drop_count_reg != DROP_CNT_MAX)
      begin
        drop_count_reg <= drop_count_reg + 8'h01;
      end
      if (push_if.valid && push_ready && key_ch[1:0] == E_CH_LOW_BITS)
      begin
        e_seen_reg <= 1'b1; // RULE4
      end
      mode_reg <= mode_active;
      in_ready_o <= 1'b1;
    end
  end

  // ready is a registered constant one after reset; the real gate is push_ready inside in_fire
  assign out_valid_o = out_valid_reg;
  assign out_word_o = out_word_reg;
  assign drop_count_o = drop_count_reg;
  assign e_route_seen_o = e_seen_reg;
  assign mode_active_o = mode_reg;

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_pcm_to_line;
    in_fire && in_source_i == SRC_PCM && route_dst == DST_LINE;
  endsequence
  sequence s_stalled_out;
    out_valid_reg && !out_ready_i;
  endsequence

  AST_COUPLE_ENABLED: assert property (s_pcm_to_line |-> (|tx_hit) && (|rx_hit)) // RULE2
    else $error("pcm to line byte passed without both fifos enabled");
  AST_COUPLE_NO_STORE: assert property (s_pcm_to_line
    |=> acc_reg[$past(key_ch)] == $past(acc_reg[key_ch])) // RULE1
    else $error("coupled byte was stored");
  AST_SLOT_LINKED: assert property (in_fire && mode_active && in_source_i == SRC_PCM
    && !slink_reg[DIR_RX][in_index_i] |-> route_dst == DST_NONE) // RULE7
    else $error("unlinked pcm slot was routed");
  AST_PCM_PCM: assert property (in_fire && mode_active && in_source_i == SRC_PCM
    && slink_reg[DIR_RX][in_index_i] && pcm_hit |-> route_dst == DST_PCM) // RULE8
    else $error("pcm to pcm path not taken");
  AST_FIFO_CHANNEL: assert property (in_fire && mode_active && in_source_i == SRC_HOST
    && route_dst == DST_LINE |-> route_idx == fch_reg[DIR_TX][in_fifo]) // RULE10
    else $error("fifo byte sent on wrong channel");
  AST_SIMPLE_MODE: assert property (in_fire && (!assign_bit_reg || seq_bit_reg)
    && in_source_i == SRC_HOST && route_dst == DST_LINE |-> route_idx == in_index_i) // RULE9
    else $error("simple mode did not keep fifo n on channel n");
  AST_FILL: assert property (in_fire && in_source_i == SRC_HOST && route_dst == DST_LINE
    |-> (route_data & ~owned) == (fill_reg & ~owned)) // RULE12
    else $error("unowned bits not taken from fill byte");
  AST_NEED_FIFO: assert property (in_fire && in_source_i == SRC_HOST
    && !fifo_live(DIR_TX, in_fifo) |=> drop_count_reg != $past(drop_count_reg)
    || $past(drop_count_reg) == DROP_CNT_MAX) // RULE6
    else $error("byte from disabled fifo not dropped");
  AST_MERGE_HOLD: assert property (in_fire && in_source_i == SRC_HOST && route_dst == DST_LINE
    |=> acc_reg[$past(key_ch)] == $past(merged)) // RULE3
    else $error("channel byte merge lost");
  AST_OUT_STALL: assert property (s_stalled_out |=> out_valid_reg && $stable(out_word_reg))
    else $error("output word changed under stall");
  AST_E_SEEN: assert property (push_if.valid && push_ready && key_ch[1:0] == E_CH_LOW_BITS
    |=> e_seen_reg [*2]) // RULE4
    else $error("e-channel route not flagged");
endmodule
`default_nettype wire

//--- test/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************
// consumer of routed words: prompt or slow
// ***************************************
module far_side_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [1:0] phase_reg;
  // slow mode takes one word in four cycles, so the buffer backs up
  always @(negedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_reg <= 2'h0;
      ready_o <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      ready_o <= !slow_i || (phase_reg == 2'h3);
    end
  end
endmodule
`default_nettype wire

//--- test/channel_select_routing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module channel_select_routing_tb_top;
  import route_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic we = 1'b0, cdir = 1'b0, cchdir = 1'b0, cen = 1'b0, in_valid = 1'b0, slow = 1'b0;
  cfg_e ctgt = CFG_FIFO;
  src_e isrc = SRC_HOST;
  logic [4:0] cidx = 5'h00, cch = 5'h00, iidx = 5'h00;
  logic [7:0] cbits = 8'h00, idata = 8'h00;
  logic in_ready, out_valid, out_ready, mode_act, e_seen;
  logic [OUT_W-1:0] out_word;
  logic [7:0] drop_cnt;
  logic [OUT_W-1:0] exp_q[$];
  int fail_count = 0, n_tests = 0, exp_drop = 0;
  logic [31:0] rnd = 32'h41;
  logic [7:0] d;
  logic [4:0] ix;

  always #4 clk_i = ~clk_i;

  channel_select_routing i_channel_select_routing (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_we_i(we), .cfg_target_i(ctgt), .cfg_dir_i(cdir), .cfg_index_i(cidx),
    .cfg_channel_i(cch), .cfg_chdir_i(cchdir), .cfg_enable_i(cen), .cfg_bits_i(cbits),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_source_i(isrc), .in_index_i(iidx),
    .in_data_i(idata), .out_valid_o(out_valid), .out_ready_i(out_ready),
    .out_word_o(out_word), .mode_active_o(mode_act), .e_route_seen_o(e_seen),
    .drop_count_o(drop_cnt));
  far_side_model i_far_side_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .ready_o(out_ready));

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [7:0] next_rnd();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd[7:0];
  endfunction

  function automatic logic [OUT_W-1:0] mk(dst_e k, logic [4:0] i, logic [7:0] m, logic [7:0] v);
    return {k, i, m, v};
  endfunction

  task automatic check(logic [OUT_W-1:0] seen, logic [OUT_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one config write; the strobe drops before the next write
  task automatic cfg(cfg_e t, logic dr, logic [4:0] i, logic [4:0] c, logic cd, logic en,
                     logic [7:0] b);
    @(negedge clk_i);
    ctgt = t;
    {cdir, cidx, cch, cchdir, cen, cbits, we} = {dr, i, c, cd, en, b, 1'b1};
    @(negedge clk_i);
    we = 1'b0;
  endtask

  // one byte; a routed byte notes its word, a dropped one bumps the drop tally
  task automatic send(src_e s, logic [4:0] i, logic [7:0] v, logic ok, logic [OUT_W-1:0] w);
    @(negedge clk_i);
    isrc = s;
    {iidx, idata, in_valid} = {i, v, 1'b1};
    if (ok)
      exp_q.push_back(w);
    else
      exp_drop++;
  endtask

  // release the input, wait for every noted word, then compare the drop tally
  task automatic drain(string name);
    int k;
    @(negedge clk_i);
    in_valid = 1'b0;
    for (k = 0; k < 200 && exp_q.size() != 0; k++)
      @(negedge clk_i);
    if (exp_q.size() != 0)
    begin
      fail_count++;
      $display("[FAIL] %0t words missing", $time);
      stop_test();
    end
    repeat (2) @(negedge clk_i);
    check(drop_cnt, exp_drop[7:0]);
    $display("test done: %s", name);
  endtask

  // ***************************************
  // output watcher: oldest note against each word taken
  // ***************************************
  always @(posedge clk_i)
  begin
    if (rst_n_i && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(out_word, {OUT_W{1'b1}});
      else
        check(out_word, exp_q.pop_front());
    end
  end

  // ***************************************
  // main sequence
  // ***************************************
  initial
  begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check({in_ready, out_valid, mode_act, e_seen, drop_cnt}, {4'h8, 8'h00});
    $display("test done: reset");
    // simple mode ignores the direction field, fifo n rides channel n
    cfg(CFG_FIFO, DIR_TX, 5'h02, 5'h11, DIR_RX, 1'b1, 8'hFF);
    slow = 1'b1;
    repeat (5)
    begin
      d = next_rnd();
      send(SRC_HOST, 5'h02, d, 1'b1, mk(DST_LINE, 5'h02, 8'h00, d));
    end
    drain("simple burst");
    slow = 1'b0;
    send(SRC_HOST, 5'h03, 8'h5A, 1'b0, '0);
    drain("simple disabled");
    // every combination of the two mode bits
    for (int m = 0; m < 5; m++)
    begin
      cfg(CFG_MODE, DIR_TX, 5'h00, 5'h00, DIR_TX, 1'b0, {6'h00, 2'(m == 4 ? 1 : m)});
      repeat (2) @(negedge clk_i);
      check(mode_act, (m == 1 || m == 4));
    end
    // tx fifo 2 has the rx direction field, so it is not live now
    send(SRC_HOST, 5'h02, 8'h33, 1'b0, '0);
    drain("mode bits");
    // pcm slot to line channel through two data-less fifos
    cfg(CFG_FIFO, DIR_TX, 5'h05, 5'h08, DIR_TX, 1'b1, 8'hFF);
    cfg(CFG_FIFO, DIR_RX, 5'h05, 5'h08, DIR_RX, 1'b1, 8'hFF);
    cfg(CFG_SLOT, DIR_RX, 5'h07, 5'h08, DIR_RX, 1'b1, 8'h00);
    d = next_rnd();
    send(SRC_PCM, 5'h07, d, 1'b1, mk(DST_LINE, 5'h08, 8'h00, d));
    drain("pcm to line");
    cfg(CFG_FIFO, DIR_RX, 5'h05, 5'h08, DIR_RX, 1'b0, 8'hFF);
    send(SRC_PCM, 5'h07, 8'h99, 1'b0, '0);
    drain("coupling blocked");
    cfg(CFG_FIFO, DIR_RX, 5'h05, 5'h08, DIR_RX, 1'b1, 8'hFF);
    cfg(CFG_SLOT, DIR_TX, 5'h07, 5'h08, DIR_TX, 1'b1, 8'h00);
    d = next_rnd();
    send(SRC_LINE, 5'h08, d, 1'b1, mk(DST_PCM, 5'h07, 8'h00, d));
    send(SRC_PCM, 5'h07, ~d, 1'b1, mk(DST_PCM, 5'h07, 8'h00, ~d));
    drain("line to pcm");
    // pcm to pcm needs no fifo; an unlinked slot goes nowhere
    cfg(CFG_FIFO, DIR_TX, 5'h05, 5'h08, DIR_TX, 1'b0, 8'hFF);
    cfg(CFG_FIFO, DIR_RX, 5'h05, 5'h08, DIR_RX, 1'b0, 8'hFF);
    send(SRC_PCM, 5'h07, 8'h6E, 1'b1, mk(DST_PCM, 5'h07, 8'h00, 8'h6E));
    send(SRC_PCM, 5'h09, 8'h12, 1'b0, '0);
    send(SRC_LINE, 5'h08, 8'h34, 1'b0, '0);
    drain("pcm to pcm");
    // two tx fifos share channel 20, each owns one nibble
    cfg(CFG_FIFO, DIR_TX, 5'h03, 5'h14, DIR_TX, 1'b1, 8'h0F);
    cfg(CFG_FIFO, DIR_TX, 5'h04, 5'h14, DIR_TX, 1'b1, 8'hF0);
    send(SRC_HOST, 5'h03, 8'h3C, 1'b1, mk(DST_LINE, 5'h14, 8'h00, 8'hFC));
    send(SRC_HOST, 5'h04, 8'h5A, 1'b1, mk(DST_LINE, 5'h14, 8'h00, 8'h5C));
    drain("shared channel");
    // unowned bits come from the fill byte; rx side reports its owned bits
    cfg(CFG_FILL, DIR_TX, 5'h00, 5'h00, DIR_TX, 1'b0, 8'hA5);
    cfg(CFG_FIFO, DIR_TX, 5'h06, 5'h0C, DIR_TX, 1'b1, 8'h0F);
    cfg(CFG_FIFO, DIR_RX, 5'h00, 5'h0C, DIR_RX, 1'b1, 8'h0F);
    send(SRC_HOST, 5'h06, 8'h3C, 1'b1, mk(DST_LINE, 5'h0C, 8'h00, 8'hAC));
    send(SRC_LINE, 5'h0C, 8'h77, 1'b1, mk(DST_HOST, 5'h0C, 8'h0F, 8'h77));
    drain("fill byte");
    // an e-channel position used as a plain routing channel
    check(e_seen, 1'b0);
    ix = 5'h1F;
    cfg(CFG_FIFO, DIR_TX, 5'h01, ix, DIR_TX, 1'b1, 8'hFF);
    d = next_rnd();
    send(SRC_HOST, 5'h01, d, 1'b1, mk(DST_LINE, ix, 8'h00, d));
    drain("e channel");
    check(e_seen, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
